/* bench/acc_props.sv */
// checker for the comparator control block, bound to its top ports.
// assumes one clock domain and the one-wait-state bus of the block.
`timescale 1ns/1ns
module acc_props (
	// clock and reset
	input wire logic                          clk,
	input wire logic                          rstn,
	// register bus
	input wire cmp_ctrl_pkg::avmm_req_t       avs_req,
	input wire logic                          avs_waitrequest,
	// comparator side
	input wire logic [2:0]                    cmp_raw,
	input wire cmp_ctrl_pkg::core_ctl_t [2:0] core_ctl,
	input wire logic [2:0]                    irq_taken,
	input wire logic [2:0]                    irq_req,
	input wire logic [2:0]                    cmp_pin_en,
	input wire logic                          cmp3_alt_en,
	// timer capture
	input wire logic                          timer_capture_edge_sel,
	input wire logic                          capture_level,
	input wire logic                          capture_event
);
	import cmp_ctrl_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic       raw0_reg;
	logic [2:0] quiet_reg;
	// decoded bus events
	wire       req   = avs_req.read | avs_req.write;
	wire       wr_ok = avs_req.write & ~avs_waitrequest & avs_req.byteenable[0];
	wire [7:0] wd    = avs_req.writedata[7:0];
	wire [4:0] ad    = avs_req.address;
	// edges since cmp1 raw last moved, so a pending set is not mistaken
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			raw0_reg  <= 1'h0;
			quiet_reg <= 3'h0;
		end else begin
			raw0_reg  <= cmp_raw[0];
			quiet_reg <= (raw0_reg != cmp_raw[0]) ? 3'h0 :
				(quiet_reg == 3'h7) ? 3'h7 : quiet_reg + 3'h1;
		end
	end
	a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state longer than one cycle");
	a_idle_ready: assert property (!req |-> !avs_waitrequest)
		else $error("wait asserted with no request");
	a_ctl1_drive:
		assert property (wr_ok && ad == OFS_CMP1_CTRL |=>
			core_ctl[0] == {$past(wd[7]), $past(wd[2:0])})
		else $error("core controls do not follow control write");
	a_alt_pin_wr:
		assert property (wr_ok && ad == OFS_CMP3_CTRL |=>
			cmp3_alt_en == $past(wd[3]))
		else $error("alternate pin enable wrong");
	a_pin_en_wr:
		assert property (wr_ok && ad == OFS_EXT_CTRL |=>
			cmp_pin_en == {3{$past(wd[4])}})
		else $error("pin enable wrong");
	a_cap_pulse: assert property (capture_event |=> !capture_event)
		else $error("capture event longer than one cycle");
	// capture_level is registered from the settled level, so it shows the
	// new value one edge after the event pulse
	a_cap_edge:
		assert property (capture_event |=> capture_level ==
			$past(timer_capture_edge_sel) &&
			capture_level != $past(capture_level))
		else $error("capture event on wrong edge");
	a_flag_w1c:
		assert property (wr_ok && ad == OFS_STATUS && wd[5] &&
			quiet_reg >= 3'h4 |=> ##1 !irq_req[0])
		else $error("flag not cleared by writing one");
	a_taken_clr:
		assert property (irq_taken[0] && irq_req[0] && quiet_reg >= 3'h4
			|=> ##1 !irq_req[0])
		else $error("flag not cleared by taken vector");
	c_capture: cover property (capture_event);
	c_taken: cover property (irq_taken[0] && irq_req[0]);
	c_w1c: cover property (wr_ok && ad == OFS_STATUS);
endmodule : acc_props

bind analog_comparator_control acc_props u_props (.clk(clk), .rstn(rstn),
	.avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
	.cmp_raw(cmp_raw), .core_ctl(core_ctl), .irq_taken(irq_taken),
	.irq_req(irq_req), .cmp_pin_en(cmp_pin_en), .cmp3_alt_en(cmp3_alt_en),
	.timer_capture_edge_sel(timer_capture_edge_sel),
	.capture_level(capture_level), .capture_event(capture_event));

/* bench/analog_comparator_control_tb.sv */
// self-checking bench for the comparator control block.
// assumes the package, the design, its checker and the core model.
`timescale 1ns/1ns
module analog_comparator_control_tb;
	import cmp_ctrl_pkg::*;
	logic            clk, rstn, waitreq, alt_en, edge_sel, cap_lvl;
	logic            cap_evt, cap_allow, alt_out3;
	avmm_req_t       req;
	logic [31:0]     rdata, q;
	logic [2:0]      raw, taken, irq, pin_out, pin_en, above;
	core_ctl_t [2:0] core_ctl;
	logic [7:0]      cap_count, base;
	int              bad_count, total_checks, cyc;
	analog_comparator_control DUT (.clk(clk), .rstn(rstn), .avs_req(req),
		.avs_waitrequest(waitreq), .avs_readdata(rdata), .cmp_raw(raw),
		.core_ctl(core_ctl), .irq_taken(taken), .irq_req(irq),
		.cmp_pin_out(pin_out), .cmp_pin_en(pin_en), .cmp3_alt_out(alt_out3),
		.cmp3_alt_en(alt_en), .timer_capture_edge_sel(edge_sel),
		.capture_level(cap_lvl), .capture_event(cap_evt));
	cmp_core_model PARTNER (.clk(clk), .core_ctl(core_ctl), .above(above),
		.cmp_raw(raw), .cap_irq_allow(cap_allow), .capture_event(cap_evt),
		.cap_count(cap_count));
	// clock and hang guard
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] g, e, input string m);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d, input logic [3:0] be);
		int n;
		@(posedge clk);
		req <= '{!w, w, a, be, {24'h0, d}};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'h0 && n < 50);
		q = rdata;
		req <= '0;
		chk(waitreq, 1'h0, "bus hang");
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'h1, a, d, 4'h1);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [7:0] e, string m);
		bus(1'h0, a, 8'h00, 4'h1);
		chk(q, {24'h0, e}, m);
	endtask : rd
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask : settle
	task automatic pulse();
		@(posedge clk);
		taken <= 3'h1;
		@(posedge clk);
		taken <= 3'h0;
	endtask : pulse
	task automatic t_regs();
		for (int i = 0; i < 6; i++) rd({i[2:0], 2'h0}, 8'h00, "reset");
		wr(OFS_CMP1_CTRL, 8'hff);
		rd(OFS_CMP1_CTRL, 8'hf7, "ctl1 mask");
		chk(core_ctl[0], 4'hf, "core1");
		wr(OFS_CMP3_CTRL, 8'hff);
		rd(OFS_CMP3_CTRL, 8'hff, "ctl3");
		chk(alt_en, 1'h1, "alt en");
		wr(OFS_EXT_CTRL, 8'hff);
		rd(OFS_EXT_CTRL, 8'h38, "ext mask");
		bus(1'h1, OFS_CMP1_CTRL, 8'h00, 4'h0);
		rd(OFS_CMP1_CTRL, 8'hf7, "lane off");
		wr(5'h14, 8'hff);
		rd(5'h14, 8'h00, "unmapped");
		for (int i = 0; i < 4; i++) wr({i[2:0], 2'h0}, 8'h00);
		$display("register test done");
	endtask : t_regs
	task automatic t_neg();
		for (int c = 0; c < 8; c++) begin
			wr(OFS_CMP2_CTRL, {5'h10, c[2:0]});
			@(negedge clk);
			chk(core_ctl[1], {1'h1, c[2:0]}, "neg sel");
		end
		wr(OFS_CMP2_CTRL, 8'h00);
		$display("select test done");
	endtask : t_neg
	task automatic t_sense();
		logic [3:0] rx, fx;
		rx = 4'h9;
		fx = 4'h5;
		wr(OFS_STATUS, 8'he0);
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CMP1_CTRL, {2'h3, s[1:0], 4'h0});
			above[0] <= 1'h1;
			settle();
			chk(irq[0], rx[s], "rise");
			rd(OFS_STATUS, {2'h0, rx[s], 5'h02}, "st rise");
			wr(OFS_STATUS, 8'h20);
			above[0] <= 1'h0;
			settle();
			chk(irq[0], fx[s], "fall");
			rd(OFS_STATUS, {2'h0, fx[s], 5'h00}, "st fall");
			wr(OFS_STATUS, 8'h20);
		end
		$display("sense test done");
	endtask : t_sense
	task automatic t_allow();
		wr(OFS_CMP1_CTRL, 8'h80);
		above[0] <= 1'h1;
		settle();
		chk(irq[0], 1'h0, "masked");
		rd(OFS_STATUS, 8'h22, "flag set");
		pulse();
		settle();
		rd(OFS_STATUS, 8'h22, "flag kept");
		wr(OFS_CMP1_CTRL, 8'hc0);
		settle();
		chk(irq[0], 1'h1, "allowed");
		pulse();
		settle();
		chk(irq[0], 1'h0, "taken");
		rd(OFS_STATUS, 8'h02, "flag gone");
		$display("allow test done");
	endtask : t_allow
	task automatic t_pins();
		wr(OFS_EXT_CTRL, 8'h10);
		settle();
		chk({pin_en, pin_out}, 6'h39, "pins");
		wr(OFS_EXT_CTRL, 8'h30);
		settle();
		chk(pin_out, 3'h0, "invert");
		chk(alt_out3, 1'h0, "alt out quiet");
		wr(OFS_EXT_CTRL, 8'h00);
		@(negedge clk);
		chk(pin_en, 3'h0, "pin off");
		$display("pin test done");
	endtask : t_pins
	task automatic t_capture();
		cap_allow <= 1'h1;
		edge_sel <= 1'h1;
		above[0] <= 1'h0;
		settle();
		base = cap_count;
		above[0] <= 1'h1;
		settle();
		chk({cap_lvl, cap_count}, {1'h0, base}, "cap off");
		above[0] <= 1'h0;
		settle();
		chk(cap_count, base, "cap off");
		wr(OFS_EXT_CTRL, 8'h08);
		for (int e = 1; e >= 0; e--) begin
			edge_sel <= e[0];
			above[0] <= 1'h1;
			settle();
			chk(cap_count, base + {7'h0, e[0]}, "cap rise");
			above[0] <= 1'h0;
			settle();
			chk(cap_count, base + 8'h01, "cap fall");
			base = base + 8'h01;
		end
		$display("capture test done");
	endtask : t_capture
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	// reset, then the scenarios in order
	initial begin
		rstn = 1'h0;
		req = '0;
		taken = 3'h0;
		edge_sel = 1'h0;
		above = 3'h0;
		cap_allow = 1'h0;
		repeat (6) @(posedge clk);
		rstn <= 1'h1;
		t_regs();
		t_neg();
		t_sense();
		t_allow();
		t_pins();
		t_capture();
		complete_run();
	end
endmodule : analog_comparator_control_tb

/* bench/cmp_core_model.sv */
// model of the analog comparator cores and the timer capture input.
// assumes the bench sets which positive inputs sit above their threshold.
`timescale 1ns/1ns
module cmp_core_model (
	// clock
	input  wire logic                          clk,
	// analog cores
	input  wire cmp_ctrl_pkg::core_ctl_t [2:0] core_ctl,
	input  wire logic [2:0]                    above,
	output logic [2:0]                         cmp_raw,
	// timer capture
	input  wire logic                          cap_irq_allow,
	input  wire logic                          capture_event,
	output logic [7:0]                         cap_count
);
	import cmp_ctrl_pkg::*;
	// a switched-off core holds its output low
	assign cmp_raw = above & {core_ctl[2].on, core_ctl[1].on, core_ctl[0].on};
	// capture interrupts count only when the timer mask allows them
	initial cap_count = 8'h00;
	always @(posedge clk) begin
		if (cap_irq_allow && capture_event === 1'h1) begin
			cap_count <= cap_count + 8'h01;
		end
	end
endmodule : cmp_core_model

/* rtl/analog_comparator_control.sv */
// digital control of three analog comparators: registers, event flags,
// interrupt requests, output pins and routing to the timer capture input.
// assumes an avalon-mm master with waitrequest on clk, raw comparator
// outputs asynchronous to clk, and vector-taken pulses from the interrupt
// controller on clk.
//
// Contract
// - control bit 7 enables its comparator.
// - control bit 6 lets the comparator request its interrupt.
// - bits 5:4 select trigger; 00 toggles, 01 is reserved.
// - sensitivity 10 raises the event on a falling output edge.
// - sensitivity 11 raises the event on a rising output edge.
// - bits 2:0 go to the negative input; 000-011 pick divided reference.
// - codes 100,101,110 pick bandgap, dac and dedicated negative pin.
// - code 111 picks the negative pin shared by all three.
// - comparator 3 bit 3 enables its alternate output pin.
// - extended bit 5 inverts the comparator output.
// - extended bit 4 enables the comparator output pin.
// - extended bit 3 routes comparator 1 to the timer capture input.
// - routed capture uses rising edge if edge select is one, else falling.
// - with capture bit clear, nothing reaches the timer capture input.
// - one shared register holds all outputs and event flags.
// - hardware sets each flag on its selected output event.
// - flag clears on its taken vector when allowed, or on writing one.
// - each output status bit reads the comparator output directly.
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module analog_comparator_control (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// avalon-mm slave
	input  wire cmp_ctrl_pkg::avmm_req_t  avs_req,
	output logic                          avs_waitrequest,
	output logic [31:0]                   avs_readdata,
	// analog comparator cores
	input  wire logic [2:0]               cmp_raw,
	output cmp_ctrl_pkg::core_ctl_t [2:0] core_ctl,
	// interrupt controller
	input  wire logic [2:0]               irq_taken,
	output logic [2:0]                    irq_req,
	// output pins
	output logic [2:0]                    cmp_pin_out,
	output logic [2:0]                    cmp_pin_en,
	output logic                          cmp3_alt_out,
	output logic                          cmp3_alt_en,
	// timer input capture
	input  wire logic                     timer_capture_edge_sel,
	output logic                          capture_level,
	output logic                          capture_event
);
	import cmp_ctrl_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	cmp_ctrl_t [2:0] ctrl_reg;
	cmp_ctrl_t [2:0] ctrl_next;
	ext_ctrl_t       ext_reg;
	ext_ctrl_t       ext_next;
	logic [2:0]      flag_reg;
	logic [2:0]      flag_next;
	logic            ack_reg;
	logic [31:0]     rdata_reg;
	logic [31:0]     rdata_next;
	logic [2:0]      pin_out_reg;
	logic            cap_level_reg;
	logic            cap_event_reg;

	logic [2:0]      level;
	logic [2:0]      rise;
	logic [2:0]      fall;
	logic [2:0]      event_hit;

	logic            req_any;
	logic            wr_take;
	logic            rd_first;
	logic            lane0;
	logic [7:0]      wbyte;
	logic [2:0]      hit_ctrl;
	logic            hit_ext;
	logic            hit_status;
	logic [7:0]      status_val;
	logic [7:0]      read_byte;
	logic [2:0]      flag_wclr;
	logic [2:0]      flag_hwclr;
	logic [2:0]      out_view;
	logic            cap_rise;
	logic            cap_fall;

	// ****************************************************************
	// functions
	// ****************************************************************

	// merge a written byte into a register under its writable mask
	function automatic logic [7:0] merge_byte(
		input logic [7:0] old_val,
		input logic [7:0] new_val,
		input logic [7:0] wmask
	);
		merge_byte = (old_val & ~wmask) | (new_val & wmask);
	endfunction : merge_byte

	// control register address for comparator index i
	function automatic logic [ADDR_W-1:0] ctrl_addr(input int i);
		unique case (i)
			0:       ctrl_addr = OFS_CMP1_CTRL;
			1:       ctrl_addr = OFS_CMP2_CTRL;
			default: ctrl_addr = OFS_CMP3_CTRL;
		endcase
	endfunction : ctrl_addr

	// ****************************************************************
	// comparator front ends
	// ****************************************************************
	for (genvar i = 0; i < 3; i++) begin : g_sense
		cmp_sense u_sense (
			.clk       (clk),
			.rstn      (rstn),
			.raw       (cmp_raw[i]),
			.on        (ctrl_reg[i].on),
			.sense     (ctrl_reg[i].sense),
			.level     (level[i]),
			.rise      (rise[i]),
			.fall      (fall[i]),
			.event_hit (event_hit[i])
		);
	end

	// ****************************************************************
	// bus decode
	// ****************************************************************

	// one wait state: the request is held while ack_reg is low
	assign req_any         = avs_req.read | avs_req.write;
	assign avs_waitrequest = req_any & ~ack_reg;
	assign wr_take         = avs_req.write & ack_reg;
	assign rd_first        = avs_req.read & ~ack_reg;
	assign lane0           = avs_req.byteenable[0];
	assign wbyte           = avs_req.writedata[7:0];

	// address hits; unmapped addresses read zero and ignore writes
	for (genvar i = 0; i < 3; i++) begin : g_hit
		assign hit_ctrl[i] = (avs_req.address == ctrl_addr(i));
	end
	assign hit_ext    = (avs_req.address == OFS_EXT_CTRL);
	assign hit_status = (avs_req.address == OFS_STATUS);

	// shared status: flags 3..1 in bits 7:5, outputs 3..1 in bits 3:1
	assign status_val = {flag_reg[2], flag_reg[1], flag_reg[0], 1'b0,
	                     level[2], level[1], level[0], 1'b0};

	// read selection
	assign read_byte = hit_ctrl[0] ? ctrl_reg[0]  :
	                   hit_ctrl[1] ? ctrl_reg[1]  :
	                   hit_ctrl[2] ? ctrl_reg[2]  :
	                   hit_ext     ? ext_reg      :
	                   hit_status  ? status_val   : 8'h00;
	assign rdata_next = rd_first ? {24'h000000, read_byte} : rdata_reg;

	// ****************************************************************
	// control register writes
	// ****************************************************************
	for (genvar i = 0; i < 3; i++) begin : g_ctrl
		assign ctrl_next[i] = (wr_take & lane0 & hit_ctrl[i])
			? merge_byte(ctrl_reg[i], wbyte,
			             (i == 2) ? CTRL3_WMASK : CTRL_WMASK)
			: ctrl_reg[i];
	end
	assign ext_next = (wr_take & lane0 & hit_ext)
		? merge_byte(ext_reg, wbyte, EXT_WMASK)
		: ext_reg;

	// ****************************************************************
	// event flags
	// ****************************************************************

	// write one clears; a taken vector clears only when allowed
	for (genvar i = 0; i < 3; i++) begin : g_flag
		assign flag_wclr[i]  = wr_take & lane0 & hit_status
		                       & wbyte[BIT_FLAG1 + i];
		assign flag_hwclr[i] = irq_taken[i] & ctrl_reg[i].irq_allow;
		// a new event wins over a clear in the same cycle
		assign flag_next[i]  = event_hit[i] |
		                       (flag_reg[i] & ~flag_wclr[i] & ~flag_hwclr[i]);
	end

	// request stands while flag and allow are both set
	assign irq_req = flag_reg & {ctrl_reg[2].irq_allow,
	                             ctrl_reg[1].irq_allow,
	                             ctrl_reg[0].irq_allow};

	// ****************************************************************
	// analog core controls
	// ****************************************************************
	for (genvar i = 0; i < 3; i++) begin : g_core
		assign core_ctl[i].on      = ctrl_reg[i].on;
		// codes 000-011 reference taps, 100 bandgap, 101 dac,
		// 110 own negative pin, 111 shared negative pin
		assign core_ctl[i].neg_sel = ctrl_reg[i].neg_sel;
	end

	// ****************************************************************
	// output pins and capture routing
	// ****************************************************************

	// optionally inverted view; a disabled comparator stays quiet
	for (genvar i = 0; i < 3; i++) begin : g_out
		assign out_view[i] = ctrl_reg[i].on
		                     & (level[i] ^ ext_reg.out_invert);
	end

	// inverted output swaps which raw edge is a rising capture edge
	assign cap_rise = ext_reg.out_invert ? fall[0] : rise[0];
	assign cap_fall = ext_reg.out_invert ? rise[0] : fall[0];

	assign cmp_pin_out  = pin_out_reg;
	assign cmp_pin_en   = {3{ext_reg.out_pin_on}};
	assign cmp3_alt_out = pin_out_reg[2];
	assign cmp3_alt_en  = ctrl_reg[2].alt_pin_on;
	assign capture_level = cap_level_reg;
	assign capture_event = cap_event_reg;
	assign avs_readdata  = rdata_reg;

	// ****************************************************************
	// registers
	// ****************************************************************

	// software-visible state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= {3{CTRL_RESET}};
			ext_reg  <= EXT_RESET;
			flag_reg <= 3'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			ext_reg  <= ext_next;
			flag_reg <= flag_next;
		end
	end

	// bus handshake and read data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg   <= req_any & ~ack_reg;
			rdata_reg <= rdata_next;
		end
	end

	// pin data and capture feed; nothing reaches capture when off
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_out_reg   <= 3'h0;
			cap_level_reg <= 1'b0;
			cap_event_reg <= 1'b0;
		end else begin
			pin_out_reg   <= out_view;
			cap_level_reg <= ext_reg.to_capture_on & out_view[0];
			cap_event_reg <= ext_reg.to_capture_on &
			                 (timer_capture_edge_sel ? cap_rise
			                                         : cap_fall);
		end
	end

endmodule : analog_comparator_control

/* rtl/cmp_ctrl_pkg.sv */
// package for the three-comparator control block: register map, field
// positions, reset values, carrier structs and the sensitivity codes.
// assumes a 32-bit avalon-mm slave port with byte addresses.
package cmp_ctrl_pkg;

	// ****************************************************************
	// register map (byte addresses, one aligned word each)
	// ****************************************************************
	localparam int          ADDR_W         = 5;
	localparam logic [4:0]  OFS_CMP1_CTRL  = 5'h00;
	localparam logic [4:0]  OFS_CMP2_CTRL  = 5'h04;
	localparam logic [4:0]  OFS_CMP3_CTRL  = 5'h08;
	localparam logic [4:0]  OFS_EXT_CTRL   = 5'h0c;
	localparam logic [4:0]  OFS_STATUS     = 5'h10;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int BIT_ON        = 7;
	localparam int BIT_IRQ_ALLOW = 6;
	localparam int BIT_SENSE_HI  = 5;
	localparam int BIT_SENSE_LO  = 4;
	localparam int BIT_ALT_PIN   = 3;
	localparam int BIT_INVERT    = 5;
	localparam int BIT_PIN_ON    = 4;
	localparam int BIT_CAPTURE   = 3;
	localparam int BIT_FLAG1     = 5;
	localparam int BIT_OUT1      = 1;

	// writable bits; the alternate pin bit exists in comparator 3 only
	localparam logic [7:0] CTRL_WMASK  = 8'hf7;
	localparam logic [7:0] CTRL3_WMASK = 8'hff;
	localparam logic [7:0] EXT_WMASK   = 8'h38;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] EXT_RESET  = 8'h00;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		SENSE_TOGGLE = 2'h0,
		SENSE_RSVD   = 2'h1,
		SENSE_FALL   = 2'h2,
		SENSE_RISE   = 2'h3
	} sense_t;

	// one comparator control register, bit 7 down to bit 0
	typedef struct packed {
		logic       on;
		logic       irq_allow;
		sense_t     sense;
		logic       alt_pin_on;
		logic [2:0] neg_sel;
	} cmp_ctrl_t;

	// extended control register, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic       out_invert;
		logic       out_pin_on;
		logic       to_capture_on;
		logic [2:0] rsvd_lo;
	} ext_ctrl_t;

	// avalon-mm request from the master
	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [3:0]        byteenable;
		logic [31:0]       writedata;
	} avmm_req_t;

	// one comparator's analog-side controls
	typedef struct packed {
		logic       on;
		logic [2:0] neg_sel;
	} core_ctl_t;

endpackage : cmp_ctrl_pkg

/* rtl/cmp_sense.sv */
// one comparator's raw output: three-stage synchroniser, agreement filter
// and edge decoding against the sensitivity code.
// assumes raw comes straight from an analog core, asynchronous to clk.
`timescale 1ns/1ns
module cmp_sense (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// raw comparator output and control
	input  wire logic                 raw,
	input  wire logic                 on,
	input  wire cmp_ctrl_pkg::sense_t sense,
	// filtered level and edges
	output logic                      level,
	output logic                      rise,
	output logic                      fall,
	output logic                      event_hit
);
	import cmp_ctrl_pkg::*;

	logic sync1_reg;
	logic sync2_reg;
	logic sync3_reg;
	logic level_reg;
	logic level_next;

	// ****************************************************************
	// synchroniser and filter
	// ****************************************************************

	// a change is taken only once stage two and three agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			level_reg <= 1'b0;
		end else begin
			sync1_reg <= raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= level_next;
		end
	end

	// a disabled comparator reads low once stages agree; switching it off while high raises one fall
	assign level_next = (sync2_reg == sync3_reg) ? (sync3_reg & on)
	                                             : level_reg;
	assign level      = level_reg;
	assign rise       = level_next & ~level_reg;
	assign fall       = ~level_next & level_reg;

	// ****************************************************************
	// sensitivity decode
	// ****************************************************************
	always_comb begin
		unique case (sense)
			SENSE_TOGGLE: event_hit = rise | fall;
			SENSE_RSVD:   event_hit = 1'b0;
			SENSE_FALL:   event_hit = fall;
			SENSE_RISE:   event_hit = rise;
		endcase
	end

endmodule : cmp_sense
